// ### hdl/pif_irq_flags.sv
// Contract
// R1: Each flag is set by its event no matter how any enable is set.
// R2: Software should clear a flag before enabling its interrupt.
// R3: The low-supply flag at bit 7 sets on a low-supply event and holds.
// R4: The collision flag at bit 3 sets on a bus collision and holds.
// R5: Bits 6 to 4 and 2 to 0 read as zero and ignore writes.
// R6: Flags reset to zero and a processor write stores the written value.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module pif_irq_flags
    import pif_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire pif_apb_req_t apbReq,
    output pif_apb_rsp_t      apbRsp,
    input  wire pif_events_t  events,
    output logic [7:0]        flagsOut,
    output logic              irq
);

    generate
        if (ADDR_W < 6 || ADDR_W > PIF_APB_AW)
        begin : g_bad_addr_w
            $error("ADDR_W must lie between 6 and 32");
        end
    endgenerate

    pif_state_t       state_reg;
    pif_apb_rsp_t     apbRsp_reg;
    logic             irq_reg;
    logic [7:0]       mask_reg;
    logic [7:0]       flagsQ;
    logic [7:0]       statusQ;
    logic [7:0]       eventVec;
    logic [7:0]       readData;
    logic [ADDR_W-3:0] wordAddr;
    logic             hitFlags;
    logic             hitStatus;
    logic             hitMask;
    logic             mapped;
    logic             accessReq;
    logic             commitWr;
    logic             wrFlags;
    logic             wrStatus;
    logic             wrMask;
    logic [7:0]       wrByte;

    // Address decode on the word index
    assign wordAddr  = apbReq.paddr[ADDR_W-1:2];
    assign hitFlags  = (wordAddr == (ADDR_W-2)'(PIF_FLAGS_IDX)) &&
                       (apbReq.paddr[1:0] == 2'h0);
    assign hitStatus = (wordAddr == (ADDR_W-2)'(PIF_STATUS_IDX)) &&
                       (apbReq.paddr[1:0] == 2'h0);
    assign hitMask   = (wordAddr == (ADDR_W-2)'(PIF_MASK_IDX)) &&
                       (apbReq.paddr[1:0] == 2'h0);
    assign mapped    = hitFlags | hitStatus | hitMask;

    assign accessReq = apbReq.psel && apbReq.penable;

    // Write lands on the edge where pready is sampled high
    assign commitWr  = (state_reg == PIF_ST_ACK) && accessReq &&
                       apbReq.pwrite;
    assign wrByte    = apbReq.pwdata[7:0] & PIF_IMPL_MASK; // R5
    assign wrFlags   = commitWr && hitFlags;
    assign wrStatus  = commitWr && hitStatus;
    assign wrMask    = commitWr && hitMask;

    // Event vector in the shared bit layout
    always_comb
    begin
        eventVec               = 8'h00;
        eventVec[PIF_LOW_BIT]  = events.lowSupply;  // R3
        eventVec[PIF_COLL_BIT] = events.collision;  // R4
    end

    // Flag and status cells for implemented positions only
    genvar gi;
    generate
        for (gi = 0; gi < PIF_REG_W; gi++)
        begin : g_bits
            if (PIF_IMPL_MASK[gi])
            begin : g_impl
                // Set path ignores mask and any global enable
                pif_flag_cell
                #(
                    .W1C     (1'b0),
                    .RST_VAL (PIF_FLAGS_RST[gi])
                )
                u_flag
                (
                    .clk    (clk),
                    .srst   (srst),
                    .setEvt (eventVec[gi]),
                    .wrEn   (wrFlags),
                    .wrBit  (wrByte[gi]),
                    .flagQ  (flagsQ[gi])
                ); // R1 R6

                pif_flag_cell
                #(
                    .W1C     (1'b1),
                    .RST_VAL (PIF_STATUS_RST[gi])
                )
                u_status
                (
                    .clk    (clk),
                    .srst   (srst),
                    .setEvt (eventVec[gi]),
                    .wrEn   (wrStatus),
                    .wrBit  (wrByte[gi]),
                    .flagQ  (statusQ[gi])
                );
            end
            else
            begin : g_unimpl
                assign flagsQ[gi]  = 1'b0; // R5
                assign statusQ[gi] = 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (srst)
            mask_reg <= PIF_MASK_RST;
        else if (wrMask)
            mask_reg <= wrByte;
    end

    always_comb
    begin
        readData = 8'h00;
        if (hitFlags)
            readData = flagsQ;
        else if (hitStatus)
            readData = statusQ;
        else if (hitMask)
            readData = mask_reg;
    end

    // One wait cycle, then pready for one cycle
    always_ff @(posedge clk)
    begin
        if (srst)
            state_reg <= PIF_ST_IDLE;
        else
        begin
            case (state_reg)
                PIF_ST_IDLE:
                    if (accessReq)
                        state_reg <= PIF_ST_ACK;
                PIF_ST_ACK:
                    state_reg <= PIF_ST_IDLE;
                default:
                    state_reg <= PIF_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            apbRsp_reg <= '0;
        else if (state_reg == PIF_ST_IDLE && accessReq)
        begin
            apbRsp_reg.pready  <= 1'b1;
            apbRsp_reg.pslverr <= ~mapped;
            apbRsp_reg.prdata  <= apbReq.pwrite ? '0 :
                                  {24'h000000, readData};
        end
        else
            apbRsp_reg <= '0;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            irq_reg <= 1'b0;
        else
            irq_reg <= |(statusQ & mask_reg);
    end

    assign apbRsp   = apbRsp_reg;
    assign irq      = irq_reg;
    assign flagsOut = flagsQ;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    low_flag_set_a: assert property ( // R3
        events.lowSupply |=> flagsQ[PIF_LOW_BIT] && statusQ[PIF_LOW_BIT])
        else $error("low-supply event did not set its flag");

    coll_flag_set_a: assert property ( // R4
        events.collision |=> flagsQ[PIF_COLL_BIT] && statusQ[PIF_COLL_BIT])
        else $error("collision event did not set its flag");

    flag_hold_a: assert property ( // R3
        flagsQ[PIF_LOW_BIT] && !wrFlags |=> flagsQ[PIF_LOW_BIT])
        else $error("low-supply flag dropped without a write");

    coll_hold_a: assert property ( // R4
        flagsQ[PIF_COLL_BIT] && !wrFlags |=> flagsQ[PIF_COLL_BIT])
        else $error("collision flag dropped without a write");

    enable_indep_a: assert property ( // R1
        mask_reg == 8'h00 && events.collision && !wrFlags && !wrMask
        |=> flagsQ[PIF_COLL_BIT] ##1 !irq)
        else $error("flag set depends on mask or irq misfired");

    unimpl_zero_a: assert property ( // R5
        apbRsp.pready |-> (apbRsp.prdata & ~{24'h000000, PIF_IMPL_MASK})
                          == '0)
        else $error("unimplemented bits read nonzero");

    write_store_a: assert property ( // R6
        wrFlags && eventVec == 8'h00
        |=> flagsQ == ($past(apbReq.pwdata[7:0]) & PIF_IMPL_MASK))
        else $error("flag write not stored");

    ready_timing_a: assert property (
        state_reg == PIF_ST_IDLE && accessReq
        |=> apbRsp.pready ##1 !apbRsp.pready)
        else $error("pready not exactly one cycle after wait");

    irq_level_a: assert property (
        (statusQ & mask_reg) != 8'h00 |=> irq)
        else $error("unmasked status did not raise irq");

    status_hold_a: assert property ( // R3
        statusQ[PIF_LOW_BIT] && !(wrStatus && wrByte[PIF_LOW_BIT])
        |=> statusQ[PIF_LOW_BIT])
        else $error("low-supply status dropped without a clear");

    status_coll_a: assert property ( // R4
        statusQ[PIF_COLL_BIT] && !(wrStatus && wrByte[PIF_COLL_BIT])
        |=> statusQ[PIF_COLL_BIT])
        else $error("collision status dropped without a clear");

    status_clear_a: assert property (
        wrStatus && eventVec == 8'h00
        |=> statusQ == ($past(statusQ) & ~$past(wrByte)))
        else $error("status write-one-to-clear misbehaved");

    mask_store_a: assert property (
        wrMask
        |=> mask_reg == $past(wrByte))
        else $error("mask write not stored");

    irq_drop_a: assert property (
        (statusQ & mask_reg) == 8'h00
        |=> !irq)
        else $error("irq high with no unmasked status");

    slverr_map_a: assert property (
        state_reg == PIF_ST_IDLE && accessReq
        |=> apbRsp.pslverr != $past(mapped))
        else $error("pslverr does not match the address decode");

    wr_rdata_zero_a: assert property (
        state_reg == PIF_ST_IDLE && accessReq && apbReq.pwrite
        |=> apbRsp.prdata == '0)
        else $error("write response carried read data");

    flags_read_a: assert property ( // R5
        state_reg == PIF_ST_IDLE && accessReq && !apbReq.pwrite && hitFlags
        |=> apbRsp.prdata == {24'h000000, $past(flagsQ)})
        else $error("flag read returned wrong data");

    no_early_ready_a: assert property (
        !(state_reg == PIF_ST_IDLE && accessReq)
        |=> !apbRsp.pready)
        else $error("pready without an accepted access");

    flag_stable_a: assert property ( // R6
        eventVec == 8'h00 && !wrFlags
        |=> $stable(flagsQ))
        else $error("flags changed with no event and no write");

    commit_once_a: assert property (
        commitWr
        |=> !commitWr)
        else $error("one access committed twice");

    flags_read_c: cover property (
        commitWr == 1'b0 && apbRsp.pready && apbRsp.prdata[PIF_LOW_BIT]);

    clear_race_c: cover property (
        wrFlags && !wrByte[PIF_COLL_BIT] && events.collision);

    irq_raise_c: cover property (!irq ##1 irq);

    status_clear_c: cover property (wrStatus && statusQ != 8'h00);

    status_race_c: cover property (
        wrStatus && wrByte[PIF_COLL_BIT] && events.collision);

endmodule // pif_irq_flags

// ### hdl/pif_pkg.sv
package pif_pkg;

    localparam int          PIF_REG_W      = 8;
    localparam int          PIF_APB_DW     = 32;
    localparam int          PIF_APB_AW     = 32;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  PIF_FLAGS_IDX  = 8'h0d;
    localparam logic [7:0]  PIF_STATUS_IDX = 8'h0e;
    localparam logic [7:0]  PIF_MASK_IDX   = 8'h0f;

    // Field positions, shared by flags, status and mask
    localparam int          PIF_LOW_BIT    = 7;
    localparam int          PIF_COLL_BIT   = 3;
    localparam logic [7:0]  PIF_IMPL_MASK  =
        (8'h01 << PIF_LOW_BIT) | (8'h01 << PIF_COLL_BIT);

    // Reset values
    localparam logic [7:0]  PIF_FLAGS_RST  = 8'h00;
    localparam logic [7:0]  PIF_STATUS_RST = 8'h00;
    localparam logic [7:0]  PIF_MASK_RST   = 8'h00;

    typedef enum logic [1:0]
    {
        PIF_ST_IDLE = 2'b01,
        PIF_ST_ACK  = 2'b10
    } pif_state_t;

    typedef struct packed
    {
        logic                  psel;
        logic                  penable;
        logic                  pwrite;
        logic [PIF_APB_AW-1:0] paddr;
        logic [PIF_APB_DW-1:0] pwdata;
    } pif_apb_req_t;

    typedef struct packed
    {
        logic                  pready;
        logic                  pslverr;
        logic [PIF_APB_DW-1:0] prdata;
    } pif_apb_rsp_t;

    typedef struct packed
    {
        logic lowSupply;
        logic collision;
    } pif_events_t;

endpackage

// ### hdl/pif_flag_cell.sv
`timescale 1ns/1ps
module pif_flag_cell
    import pif_pkg::*;
#(
    parameter bit W1C     = 1'b0,
    parameter bit RST_VAL = 1'b0
)
(
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic setEvt,
    input  wire logic wrEn,
    input  wire logic wrBit,
    output logic      flagQ
);

    logic flag_reg;
    logic flag_next;

    // Hardware set always beats a software clear
    always_comb
    begin
        if (W1C)
            flag_next = setEvt | (flag_reg & ~(wrEn & wrBit));
        else
            flag_next = setEvt | (wrEn ? wrBit : flag_reg);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            flag_reg <= RST_VAL;
        else
            flag_reg <= flag_next;
    end

    assign flagQ = flag_reg;

endmodule // pif_flag_cell

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import pif_pkg::*;

    localparam logic [31:0] A_FLAGS  = {22'h0, PIF_FLAGS_IDX, 2'b00};
    localparam logic [31:0] A_STATUS = {22'h0, PIF_STATUS_IDX, 2'b00};
    localparam logic [31:0] A_MASK   = {22'h0, PIF_MASK_IDX, 2'b00};

    logic         clk;
    logic         srst;
    pif_apb_req_t apbReq;
    pif_apb_rsp_t apbRsp;
    pif_events_t  events;
    logic [7:0]   flagsOut;
    logic         irq;
    logic [31:0]  rd;
    logic         err;
    int           errors;
    int           n_checks;

    pif_irq_flags #(.ADDR_W(8)) DUT
    (
        .clk      (clk),
        .srst     (srst),
        .apbReq   (apbReq),
        .apbRsp   (apbRsp),
        .events   (events),
        .flagsOut (flagsOut),
        .irq      (irq)
    );

    always #2.5 clk = ~clk;

    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Setup, then access until pready; release and let one edge pass
    task automatic apb(input logic wr, input logic [31:0] addr,
                       input logic [31:0] wd);
        int n;
        n = 0;
        apbReq <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:addr,
                   pwdata:wd};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (apbRsp.pready !== 1'b1 && n < 50);
        if (n >= 50)
            errors++;
        rd = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq <= '0;
        @(posedge clk);
    endtask

    task automatic rdc(input logic [31:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        chk(rd, exp);
    endtask

    task automatic pulse(input pif_events_t e);
        events <= e;
        @(posedge clk);
        events <= '0;
        repeat (2) @(posedge clk);
    endtask

    // Raise a collision only at the edge where the write commits
    task automatic race_wr(input logic [31:0] addr, input logic [31:0] wd);
        fork
            apb(1'b1, addr, wd);
            begin
                repeat (2) @(posedge clk);
                events <= '{lowSupply:1'b0, collision:1'b1};
                @(posedge clk);
                events <= '0;
            end
        join
    endtask

    initial
    begin
        clk = 1'b0;
        srst = 1'b1;
        apbReq = '0;
        events = '0;
        errors = 0;
        n_checks = 0;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rdc(A_FLAGS, 32'h0);
        rdc(A_STATUS, 32'h0);
        rdc(A_MASK, 32'h0);
        $display("Test reset values done");
        apb(1'b1, A_FLAGS, 32'hffffffff);
        rdc(A_FLAGS, 32'h88);
        chk({24'h0, flagsOut}, 32'h88);
        apb(1'b1, A_FLAGS, 32'h0);
        rdc(A_FLAGS, 32'h0);
        $display("Test store and unimplemented bits done");
        pulse('{lowSupply:1'b1, collision:1'b0});
        repeat (4) @(posedge clk);
        rdc(A_FLAGS, 32'h80);
        rdc(A_STATUS, 32'h80);
        chk({31'h0, irq}, 32'h0);
        pulse('{lowSupply:1'b0, collision:1'b1});
        rdc(A_FLAGS, 32'h88);
        chk({24'h0, flagsOut}, 32'h88);
        $display("Test sticky events done");
        apb(1'b1, A_MASK, 32'h80);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, A_STATUS, 32'h80);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        rdc(A_STATUS, 32'h08);
        rdc(A_FLAGS, 32'h88);
        apb(1'b1, A_FLAGS, 32'h08);
        rdc(A_FLAGS, 32'h08);
        $display("Test interrupt raise and clear done");
        apb(1'b1, A_STATUS, 32'h88);
        apb(1'b1, A_MASK, 32'hff);
        rdc(A_MASK, 32'h88);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        pulse('{lowSupply:1'b0, collision:1'b1});
        chk({31'h0, irq}, 32'h1);
        $display("Test clear before enable done");
        apb(1'b1, A_FLAGS, 32'h88);
        race_wr(A_FLAGS, 32'h0);
        rdc(A_FLAGS, 32'h08);
        race_wr(A_STATUS, 32'h08);
        rdc(A_STATUS, 32'h08);
        apb(1'b1, A_STATUS, 32'h08);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        rdc(A_STATUS, 32'h0);
        $display("Test set beats clear done");
        apb(1'b0, 32'h00000000, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b0, A_FLAGS + 32'h1, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        $display("Test unmapped access done");
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rdc(A_FLAGS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        rdc(A_MASK, 32'h0);
        $display("Test mid-run reset done");
        end_sim();
    end

    // Whole sequence takes about 160 cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        end_sim();
    end

endmodule // tb_top
